// File: hdl/upe_pkg.sv
// constants, field layouts and types shared by the under-power element
// assumes a 100 MHz system clock and a 32-bit apb register bus
package upe_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_POWER  = 8'h08;
  localparam logic [7:0] OFS_ANGLE  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT  = 8'h14;

  localparam int STAT_START_BIT = 0;
  localparam int STAT_TRIP_BIT  = 1;
  localparam int EVT_W          = 4;
  localparam int CTRL_W         = 2;

  // ------------------------------------------------------------------
  // setting ranges and reset values
  // ------------------------------------------------------------------
  localparam int              DELAY_W   = 16;
  localparam logic [15:0]     DELAY_MIN = 16'h00C8;
  localparam logic [15:0]     DELAY_MAX = 16'hEA60;
  localparam logic [15:0]     DELAY_RST = 16'h00C8;
  // start power in tenths of a percent
  localparam int              POWER_W   = 11;
  localparam logic [10:0]     POWER_MIN = 11'h00A;
  localparam logic [10:0]     POWER_MAX = 11'h7D0;
  localparam logic [10:0]     POWER_RST = 11'h064;
  localparam int              ANGLE_W   = 9;
  localparam logic signed [8:0] ANGLE_MIN = 9'h14D;
  localparam logic signed [8:0] ANGLE_MAX = 9'h0B4;
  localparam logic signed [8:0] ANGLE_RST = 9'h000;
  // hysteresis ratio 1.05 as a fraction
  localparam int              THR_W     = 12;
  localparam int              PROD_W    = 18;
  localparam logic [6:0]      HYST_NUM  = 7'h69;
  localparam logic [6:0]      HYST_DEN  = 7'h64;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int TIME_MS_NS    = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_CYCLES     = TIME_MS_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic startOnly;
    logic enable;
  } upe_ctrl_type;

  typedef struct packed {
    logic tripOff;
    logic tripOn;
    logic startOff;
    logic startOn;
  } upe_evt_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_TIMING = 3'b010,
    ST_TRIP   = 3'b100
  } upe_state_type;

  function automatic logic in_range_u(input logic [31:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range_u

  function automatic logic in_range_s(input logic signed [31:0] v,
                                      input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_range_s

  function automatic logic [THR_W-1:0] hyst_thr(
      input logic [POWER_W-1:0] p);
    logic [PROD_W-1:0] prod;
    prod = PROD_W'(p) * PROD_W'(HYST_NUM);
    return THR_W'(prod / PROD_W'(HYST_DEN));
  endfunction : hyst_thr

endpackage : upe_pkg

// File: hdl/upe_ms_tick.sv
// millisecond tick generator for the definite delay timer
// assumes clr is a same-clock level; tick is a one-cycle pulse
`timescale 1ns/1ps
module upe_ms_tick #(
  parameter int CYCLES = upe_pkg::MS_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic clr,
  output logic      tick
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cntQ;
  wire           wrapW = (cntQ == LAST);

  // restarting on clr keeps the first tick a full period away
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cntQ <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      cntQ <= (clr || wrapW) ? '0 : CW'(cntQ + 1'b1);
      tick <= !clr && wrapW;
    end
  end
endmodule : upe_ms_tick

// File: hdl/upe_edge_evt.sv
// on and off event pulses for one status level
// assumes level comes from a flip-flop on the same clock
`timescale 1ns/1ps
module upe_edge_evt (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prevQ;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prevQ <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else if (ce) begin
      prevQ <= level;
      rise  <= level && !prevQ;
      fall  <= !level && prevQ;
    end
  end
endmodule : upe_edge_evt

// File: hdl/upe_underpower_element.sv
// decision, definite delay and apb registers of the under-power element
// assumes operateFlag and both block inputs come from same-clock logic
//
// Operation
// - start only while operate flag true and general block low
// - voltage supervision block suppresses start regardless of general block
// - with trip wanted, delay timing begins as start becomes active
// - trip asserts when the running timer reaches the set delay
// - start-only selection, default false, forbids trip when true
// - delay held in ms, 200 to 60000 step 1, reset 200
// - start power 1.0 to 200.0 percent, default 10.0, sent upstream
// - direction angle -179 to 180 degrees, default 0, sent upstream
// - event on every rise and fall of start and trip
// - current start and trip states readable at all times
// - after operating the threshold grows by ratio 1.05
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module upe_underpower_element #(
  parameter int MS_CYCLES = upe_pkg::MS_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  input  wire logic                         ce,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [upe_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         operateFlag,
  input  wire logic                         generalBlockIn,
  input  wire logic                         voltageSupervisionBlockIn,
  output logic                              startOut,
  output logic                              tripOut,
  output upe_pkg::upe_evt_type              evtOut,
  output logic [upe_pkg::THR_W-1:0]         startPowerOut,
  output logic signed [upe_pkg::ANGLE_W-1:0] angleOut
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  upe_pkg::upe_ctrl_type                ctrlQ;
  logic [upe_pkg::DELAY_W-1:0]          delayQ;
  logic [upe_pkg::POWER_W-1:0]          powerQ;
  logic signed [upe_pkg::ANGLE_W-1:0]   angleQ;
  logic [upe_pkg::EVT_W-1:0]            stickyQ;
  logic [upe_pkg::EVT_W-1:0]            stickyD;
  upe_pkg::upe_state_type               stQ;
  upe_pkg::upe_state_type               stD;
  logic [upe_pkg::DELAY_W-1:0]          msCntQ;
  logic [upe_pkg::DELAY_W-1:0]          msCntD;
  logic                                 startQ;
  logic                                 tripQ;
  logic                                 tickW;
  logic                                 startRise;
  logic                                 startFall;
  logic                                 tripRise;
  logic                                 tripFall;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  wire setupW  = psel && !penable;
  wire accessW = psel && penable && pready;
  wire wrW     = accessW && pwrite;

  wire selCtrl   = (paddr == upe_pkg::OFS_CTRL);
  wire selDelay  = (paddr == upe_pkg::OFS_DELAY);
  wire selPower  = (paddr == upe_pkg::OFS_POWER);
  wire selAngle  = (paddr == upe_pkg::OFS_ANGLE);
  wire selStatus = (paddr == upe_pkg::OFS_STATUS);
  wire selEvent  = (paddr == upe_pkg::OFS_EVENT);
  wire mappedW   = selCtrl || selDelay || selPower || selAngle ||
                   selStatus || selEvent;

  // settings outside their range are refused rather than clamped
  wire delayOk = upe_pkg::in_range_u(pwdata, 32'(upe_pkg::DELAY_MIN),
                                     32'(upe_pkg::DELAY_MAX));
  wire powerOk = upe_pkg::in_range_u(pwdata, 32'(upe_pkg::POWER_MIN),
                                     32'(upe_pkg::POWER_MAX));
  wire angleOk = upe_pkg::in_range_s(pwdata, 32'(upe_pkg::ANGLE_MIN),
                                     32'(upe_pkg::ANGLE_MAX));

  wire badW = !mappedW || (pwrite && ((selDelay && !delayOk) ||
              (selPower && !powerOk) || (selAngle && !angleOk) ||
              selStatus));
  wire goodWr = wrW && !badW;

  wire [31:0] statusW = {30'h0, tripQ, startQ};
  wire [31:0] rdW =
    selCtrl   ? {30'h0, ctrlQ}                       :
    selDelay  ? {16'h0, delayQ}                      :
    selPower  ? {21'h0, powerQ}                      :
    selAngle  ? {23'h0, angleQ}                      :
    selStatus ? statusW                              :
    selEvent  ? {28'h0, stickyQ}                     : 32'h0;

  // ------------------------------------------------------------------
  // apb response
  // ------------------------------------------------------------------
  // no wait state: pready rises in the first access cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      pready  <= setupW;
      pslverr <= setupW && badW;
      prdata  <= setupW ? rdW : 32'h0;
    end
  end

  // ------------------------------------------------------------------
  // settings
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlQ  <= '0;
      delayQ <= upe_pkg::DELAY_RST;
      powerQ <= upe_pkg::POWER_RST;
      angleQ <= upe_pkg::ANGLE_RST;
    end else if (ce && goodWr) begin
      if (selCtrl) begin
        ctrlQ <= upe_pkg::upe_ctrl_type'(pwdata[upe_pkg::CTRL_W-1:0]);
      end
      if (selDelay) begin
        delayQ <= pwdata[upe_pkg::DELAY_W-1:0];
      end
      if (selPower) begin
        powerQ <= pwdata[upe_pkg::POWER_W-1:0];
      end
      if (selAngle) begin
        angleQ <= pwdata[upe_pkg::ANGLE_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // sticky event flags, write one to clear
  // ------------------------------------------------------------------
  wire [upe_pkg::EVT_W-1:0] evtNowW = {tripFall, tripRise,
                                       startFall, startRise};
  wire [upe_pkg::EVT_W-1:0] clrW =
    (goodWr && selEvent) ? pwdata[upe_pkg::EVT_W-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  assign stickyD = (stickyQ & ~clrW) | evtNowW;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stickyQ <= '0;
    end else if (ce) begin
      stickyQ <= stickyD;
    end
  end

  // ------------------------------------------------------------------
  // start decision
  // ------------------------------------------------------------------
  wire startD = ctrlQ.enable && operateFlag &&
                !generalBlockIn &&
                !voltageSupervisionBlockIn;
  wire holdW  = startD && !ctrlQ.startOnly;

  // ------------------------------------------------------------------
  // definite delay
  // ------------------------------------------------------------------
  wire [upe_pkg::DELAY_W-1:0] cntNextW = msCntQ + 16'h0001;
  wire expireW = tickW && (cntNextW >= delayQ);

  always_comb begin
    stD = upe_pkg::ST_IDLE;
    case (stQ)
      upe_pkg::ST_IDLE: begin
        stD = holdW ? upe_pkg::ST_TIMING : upe_pkg::ST_IDLE;
      end
      upe_pkg::ST_TIMING: begin
        if (!holdW) begin
          stD = upe_pkg::ST_IDLE;
        end else if (expireW) begin
          stD = upe_pkg::ST_TRIP;
        end else begin
          stD = upe_pkg::ST_TIMING;
        end
      end
      upe_pkg::ST_TRIP: begin
        stD = holdW ? upe_pkg::ST_TRIP : upe_pkg::ST_IDLE;
      end
      default: begin
        stD = upe_pkg::ST_IDLE;
      end
    endcase
  end

  assign msCntD = (stD == upe_pkg::ST_IDLE) ? '0 :
                  (tickW && stQ == upe_pkg::ST_TIMING) ? cntNextW :
                  msCntQ;

  upe_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .clr     (stQ != upe_pkg::ST_TIMING),
    .tick    (tickW)
  );

  // start, trip and the timer move on the same edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stQ    <= upe_pkg::ST_IDLE;
      msCntQ <= '0;
      startQ <= 1'b0;
      tripQ  <= 1'b0;
    end else if (ce) begin
      stQ    <= stD;
      msCntQ <= msCntD;
      startQ <= startD;
      tripQ  <= (stD == upe_pkg::ST_TRIP);
    end
  end

  // ------------------------------------------------------------------
  // settings toward the directional comparison
  // ------------------------------------------------------------------
  // hysteresis follows start, so a blocked element drops back at once
  wire [upe_pkg::THR_W-1:0] thrW =
    startQ ? upe_pkg::hyst_thr(powerQ) :
             upe_pkg::THR_W'(powerQ);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      startPowerOut <= upe_pkg::THR_W'(upe_pkg::POWER_RST);
      angleOut      <= upe_pkg::ANGLE_RST;
    end else if (ce) begin
      startPowerOut <= thrW;
      angleOut      <= angleQ;
    end
  end

  assign startOut = startQ;
  assign tripOut  = tripQ;

  // ------------------------------------------------------------------
  // events
  // ------------------------------------------------------------------
  upe_edge_evt u_startEvt (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .level   (startQ),
    .rise    (startRise),
    .fall    (startFall)
  );

  upe_edge_evt u_tripEvt (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .level   (tripQ),
    .rise    (tripRise),
    .fall    (tripFall)
  );

  assign evtOut = upe_pkg::upe_evt_type'(evtNowW);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_startRise;
    ce ##0 $rose(startQ);
  endsequence
  sequence s_tripFall;
    ce ##0 $fell(tripQ);
  endsequence

  property p_startCause;
    $rose(startQ) |-> $past(operateFlag) && !$past(generalBlockIn);
  endproperty
  a_startCause: assert property (p_startCause)
    else $error("start rose without operate or while blocked");

  property p_vtsBlock;
    ce && voltageSupervisionBlockIn |=> !startQ;
  endproperty
  a_vtsBlock: assert property (p_vtsBlock)
    else $error("start active under voltage supervision block");

  property p_timerBegins;
    ce && holdW && stQ == upe_pkg::ST_IDLE |=>
      stQ == upe_pkg::ST_TIMING && startQ && msCntQ == '0;
  endproperty
  a_timerBegins: assert property (p_timerBegins)
    else $error("delay timing did not begin with start");

  property p_tripAtDelay;
    $rose(tripQ) |-> msCntQ >= delayQ && $past(stQ) == upe_pkg::ST_TIMING;
  endproperty
  a_tripAtDelay: assert property (p_tripAtDelay)
    else $error("trip rose before the delay elapsed");

  property p_startOnlyNoTrip;
    ce && ctrlQ.startOnly |=> !tripQ;
  endproperty
  a_startOnlyNoTrip: assert property (p_startOnlyNoTrip)
    else $error("trip active in start-only mode");

  property p_delayRange;
    delayQ >= upe_pkg::DELAY_MIN && delayQ <= upe_pkg::DELAY_MAX;
  endproperty
  a_delayRange: assert property (p_delayRange)
    else $error("delay setting out of range");

  property p_thrFollows;
    ce |=> startPowerOut == ($past(startQ) ?
      upe_pkg::hyst_thr($past(powerQ)) :
      upe_pkg::THR_W'($past(powerQ)));
  endproperty
  a_thrFollows: assert property (p_thrFollows)
    else $error("threshold output wrong for start state");

  property p_angleRange;
    angleQ >= upe_pkg::ANGLE_MIN && angleQ <= upe_pkg::ANGLE_MAX;
  endproperty
  a_angleRange: assert property (p_angleRange)
    else $error("angle setting out of range");

  property p_startOnEvt;
    s_startRise |=> evtOut.startOn ##1 !evtOut.startOn || !ce;
  endproperty
  a_startOnEvt: assert property (p_startOnEvt)
    else $error("no single start-on event");

  property p_tripOffEvt;
    s_tripFall |=> evtOut.tripOff ##1 (stickyQ[3] || !$past(ce));
  endproperty
  a_tripOffEvt: assert property (p_tripOffEvt)
    else $error("no trip-off event");

  property p_statusRead;
    ce && setupW && selStatus |=>
      prdata[upe_pkg::STAT_START_BIT] == $past(startQ) &&
      prdata[upe_pkg::STAT_TRIP_BIT] == $past(tripQ) && pready;
  endproperty
  a_statusRead: assert property (p_statusRead)
    else $error("status read does not show start and trip");

  property p_disabledIdle;
    ce && !ctrlQ.enable |=> !startQ && !tripQ && msCntQ == '0;
  endproperty
  a_disabledIdle: assert property (p_disabledIdle)
    else $error("outputs or timer active while off");

  property p_dropClears;
    ce && startQ && !startD |=> !startQ && !tripQ && msCntQ == '0 &&
      stQ == upe_pkg::ST_IDLE;
  endproperty
  a_dropClears: assert property (p_dropClears)
    else $error("timer or trip survived start drop");

endmodule : upe_underpower_element

// File: tb/upe_power_model.sv
// upstream directional comparison standing in front of the element
// assumes measPower and thr share the 0.1 percent scale
`timescale 1ns/1ps
module upe_power_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [11:0] measPower,
  input  wire logic [11:0] thr,
  output logic             operateFlag
);
  // ------------------------------------------------------------------
  // decision
  // ------------------------------------------------------------------
  // measPower is the three-phase total along the set direction
  // thr already carries the enlarged value while started
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      operateFlag <= 1'b0;
    end else begin
      operateFlag <= (measPower < thr);
    end
  end
endmodule : upe_power_model

// File: tb/upe_underpower_element_tb_top.sv
// self-checking bench for the under-power element over apb
// assumes a 10 cycle millisecond tick so a 200 ms delay is 2001 cycles
`timescale 1ns/1ps
module upe_underpower_element_tb_top;
  localparam int MSC = 10;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic opFlag, genBlk, vtsBlk, startOut, tripOut;
  logic [11:0] measPower, thr;
  logic signed [8:0] angleOut;
  upe_pkg::upe_evt_type evtOut;
  int n_errors = 0;
  int n_checks = 0;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  upe_underpower_element #(.MS_CYCLES(MSC)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .operateFlag(opFlag), .generalBlockIn(genBlk),
    .voltageSupervisionBlockIn(vtsBlk), .startOut(startOut),
    .tripOut(tripOut), .evtOut(evtOut), .startPowerOut(thr),
    .angleOut(angleOut));

  upe_power_model u_far (.sys_clk(sys_clk), .resetn(resetn),
    .measPower(measPower), .thr(thr), .operateFlag(opFlag));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; expD checked on reads only
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] expD,
                      input logic expE);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung access
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", {31'h0, expE}, {31'h0, pslverr});
    if (!w) chk("prdata", expD, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // wait at falling edges, bounded, for startOut to reach a level
  task automatic waitStart(input logic lvl);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (startOut !== lvl && k < 10);
    chk("startOut", {31'h0, lvl}, {31'h0, startOut});
    // callers drive the next inputs on a rising edge
    @(posedge sys_clk);
  endtask : waitStart

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    #(20000 * 10);
    n_errors++;
    print_verdict();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    int n;
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; genBlk = 1'b0; vtsBlk = 1'b0;
    measPower = 12'h032;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    xfer(0, upe_pkg::OFS_CTRL, 0, 32'h0, 0);
    xfer(0, upe_pkg::OFS_DELAY, 0, 32'h0C8, 0);
    xfer(0, upe_pkg::OFS_POWER, 0, 32'h064, 0);
    xfer(0, upe_pkg::OFS_ANGLE, 0, 32'h0, 0);
    xfer(0, upe_pkg::OFS_STATUS, 0, 32'h0, 0);
    chk("startPowerOut", 32'h064, {20'h0, thr});
    chk("startOut off", 32'h0, {31'h0, startOut});
    $display("test defaults done");
    xfer(1, upe_pkg::OFS_DELAY, 32'h0C7, 0, 1);
    xfer(1, upe_pkg::OFS_DELAY, 32'hEA61, 0, 1);
    xfer(1, upe_pkg::OFS_POWER, 32'h009, 0, 1);
    xfer(1, upe_pkg::OFS_POWER, 32'h7D1, 0, 1);
    xfer(1, upe_pkg::OFS_ANGLE, 32'hFFFFFF4C, 0, 1);
    xfer(1, upe_pkg::OFS_STATUS, 32'h3, 0, 1);
    xfer(0, 8'h18, 0, 32'h0, 1);
    xfer(0, upe_pkg::OFS_DELAY, 0, 32'h0C8, 0);
    xfer(1, upe_pkg::OFS_POWER, 32'h7D0, 0, 0);
    xfer(0, upe_pkg::OFS_POWER, 0, 32'h7D0, 0);
    xfer(1, upe_pkg::OFS_POWER, 32'h064, 0, 0);
    xfer(1, upe_pkg::OFS_ANGLE, 32'h0B4, 0, 0);
    xfer(1, upe_pkg::OFS_ANGLE, 32'hFFFFFF4D, 0, 0);
    xfer(0, upe_pkg::OFS_ANGLE, 0, 32'h14D, 0);
    chk("angleOut", 32'h14D, {23'h0, angleOut});
    xfer(1, upe_pkg::OFS_DELAY, 32'hEA60, 0, 0);
    xfer(0, upe_pkg::OFS_DELAY, 0, 32'hEA60, 0);
    xfer(1, upe_pkg::OFS_DELAY, 32'h0C8, 0, 0);
    $display("test refusals done");
    xfer(1, upe_pkg::OFS_CTRL, 32'h1, 0, 0);
    waitStart(1'b1);
    n = 0;
    while (tripOut !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("trip delay", 200 * MSC + 1, n);
    chk("startPowerOut hyst", 32'h069, {20'h0, thr});
    xfer(0, upe_pkg::OFS_STATUS, 0, 32'h3, 0);
    xfer(0, upe_pkg::OFS_EVENT, 0, 32'h5, 0);
    xfer(1, upe_pkg::OFS_EVENT, 32'hF, 0, 0);
    xfer(0, upe_pkg::OFS_EVENT, 0, 32'h0, 0);
    genBlk <= 1'b1;
    waitStart(1'b0);
    @(negedge sys_clk);
    chk("tripOut drop", 32'h0, {31'h0, tripOut});
    chk("evtOut off", 32'hA, {28'h0, evtOut});
    // sticky flags latch the pulses one edge later
    repeat (2) @(posedge sys_clk);
    xfer(0, upe_pkg::OFS_EVENT, 0, 32'hA, 0);
    $display("test trip done");
    genBlk <= 1'b0;
    waitStart(1'b1);
    vtsBlk <= 1'b1;
    waitStart(1'b0);
    repeat (30) @(negedge sys_clk);
    chk("vts hold", 32'h0, {31'h0, startOut});
    @(posedge sys_clk);
    vtsBlk <= 1'b0;
    xfer(1, upe_pkg::OFS_CTRL, 32'h3, 0, 0);
    waitStart(1'b1);
    measPower <= 12'h067;
    repeat (2100) @(negedge sys_clk);
    chk("start kept", 32'h1, {31'h0, startOut});
    chk("no trip", 32'h0, {31'h0, tripOut});
    @(posedge sys_clk);
    measPower <= 12'h06A;
    waitStart(1'b0);
    $display("test start only done");
    measPower <= 12'h032;
    waitStart(1'b1);
    xfer(1, upe_pkg::OFS_CTRL, 32'h0, 0, 0);
    waitStart(1'b0);
    $display("test disable done");
    print_verdict();
  end
endmodule : upe_underpower_element_tb_top
